// ===== verilog/gpz_params.svh
/*
 * Constants for the port 0..2 GPIO block: addresses, reset values,
 * widths and alternate-function bit positions.
 * Assumes the includer compares a full 32-bit bus address.
 */
// Behaviour
// - every register is read or written as a whole byte or one bit
// - port 0 direction register sets each port 0 pin input or output
// - direction bit 0 enables the output buffer, 1 makes the pin an input
// - port 0 direction resets to 1fh, bits 7 to 5 read zero
// - port 0 pull-up register has bits 4 to 0, resets to 00h
// - pull-up bit 1 connects the resistor, 0 leaves it off
// - port 1 is a 7-bit port with per-pin direction
// - port 1 data holds bits 6 to 0 and resets to 00h
// - port 1 control mode gives pins to serial, uart and interrupt use
// - port 1 bits map to serial in/out/clock, uart 1 and uart 2 lines
// - port 1 direction in port mode; function select picks control mode
// - port 1 direction resets to 7fh, bit 7 reads zero
// - port 1 pull-up register has bits 6 to 0, resets to 00h
// - port 2 is an 8-bit port with per-pin direction
// - port 2 data holds bits 7 to 0 and resets to 00h
// - port 2 control mode gives pins to the timer units
// - port 0 is 5-bit; pins also feed nmi and interrupt requests
`ifndef GPZ_PARAMS_SVH
`define GPZ_PARAMS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define GPZ_ADDR_P0_DATA   32'hfffff000
`define GPZ_ADDR_P1_DATA   32'hfffff002
`define GPZ_ADDR_P2_DATA   32'hfffff004
`define GPZ_ADDR_P0_DIR    32'hfffff020
`define GPZ_ADDR_P1_DIR    32'hfffff022
`define GPZ_ADDR_P2_DIR    32'hfffff024
`define GPZ_ADDR_P1_FUNC   32'hfffff042
`define GPZ_ADDR_P2_FUNC   32'hfffff044
`define GPZ_ADDR_P0_PU     32'hfffff080
`define GPZ_ADDR_P1_PU     32'hfffff082

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define GPZ_RST_DATA       8'h00
`define GPZ_RST_P0_DIR     8'h1f
`define GPZ_RST_P1_DIR     8'h7f
`define GPZ_RST_P2_DIR     8'hff
`define GPZ_RST_PU         8'h00
`define GPZ_RST_FUNC       8'h00
`define GPZ_P0_WIDTH       5
`define GPZ_P1_WIDTH       7
`define GPZ_P2_WIDTH       8

// ------------------------------------------------------------
// port 1 alternate-function bit positions
// ------------------------------------------------------------
`define GPZ_B_SER_IN       0
`define GPZ_B_SER_OUT      1
`define GPZ_B_SER_CLK      2
`define GPZ_B_U1_RX        3
`define GPZ_B_U1_TX        4
`define GPZ_B_U2_RX        5
`define GPZ_B_U2_TX        6

`endif

// ===== verilog/gpz_pkg.sv
/*
 * Types shared by the port 0..2 GPIO block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package gpz_pkg;
    // one byte of register data
    typedef logic [7:0] gpz_byte_t;
    // register selected by the bus address, one-hot
    typedef enum logic [10:0] {
        SEL_NONE    = 11'h001,
        SEL_P0_DATA = 11'h002,
        SEL_P1_DATA = 11'h004,
        SEL_P2_DATA = 11'h008,
        SEL_P0_DIR  = 11'h010,
        SEL_P1_DIR  = 11'h020,
        SEL_P2_DIR  = 11'h040,
        SEL_P1_FUNC = 11'h080,
        SEL_P2_FUNC = 11'h100,
        SEL_P0_PU   = 11'h200,
        SEL_P1_PU   = 11'h400
    } gpz_sel_t;
endpackage
`default_nettype wire

// ===== verilog/gpz_top.sv
/*
 * GPIO ports 0, 1 and 2: data, direction, pull-up and function-select
 * registers, pin drivers and alternate-function routing.
 * Assumes pins and peripheral signals are synchronous to MCLK_I and
 * that an outside pad resolves pin level from OUT/OE.
 */
`timescale 1ns/10ps
`include "gpz_params.svh"
`default_nettype none
module gpz_top #(
    parameter int P0_W = `GPZ_P0_WIDTH,
    parameter int P1_W = `GPZ_P1_WIDTH,
    parameter int P2_W = `GPZ_P2_WIDTH
) (
    // clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RESETN_I,
    // register port
    input  wire logic [31:0]       ADDR_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    input  wire logic              BITOP_I,
    input  wire logic [2:0]        BITSEL_I,
    output logic      [7:0]        RDATA_O,
    // port 0 pins
    input  wire logic [P0_W-1:0]   P0_IN_I,
    output logic      [P0_W-1:0]   P0_OUT_O,
    output logic      [P0_W-1:0]   P0_OE_O,
    output logic      [P0_W-1:0]   P0_PULLUP_O,
    output logic      [P0_W-1:0]   P0_IRQ_IN_O,
    // port 1 pins
    input  wire logic [P1_W-1:0]   P1_IN_I,
    output logic      [P1_W-1:0]   P1_OUT_O,
    output logic      [P1_W-1:0]   P1_OE_O,
    output logic      [P1_W-1:0]   P1_PULLUP_O,
    // port 1 peripheral side
    output logic                   SYNC_SERIAL_IN_O,
    input  wire logic              SYNC_SERIAL_OUT_I,
    input  wire logic              SYNC_SERIAL_CLOCK_I,
    input  wire logic              SYNC_SERIAL_CLOCK_OE_I,
    output logic                   SYNC_SERIAL_CLOCK_O,
    output logic                   FIRST_UART_RECEIVE_O,
    output logic                   EXT_INTERRUPT_FOUR_O,
    input  wire logic              FIRST_UART_TRANSMIT_I,
    output logic                   SECOND_UART_RECEIVE_O,
    output logic                   EXT_INTERRUPT_FIVE_O,
    input  wire logic              SECOND_UART_TRANSMIT_I,
    // port 2 pins
    input  wire logic [P2_W-1:0]   P2_IN_I,
    output logic      [P2_W-1:0]   P2_OUT_O,
    output logic      [P2_W-1:0]   P2_OE_O,
    // port 2 timer side
    output logic      [P2_W-1:0]   TIMER_IN_O,
    input  wire logic [P2_W-1:0]   TIMER_OUT_I,
    input  wire logic [P2_W-1:0]   TIMER_OE_I
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // port 1 alternate map is fixed to seven pins, so port 1 and 2 widths are pinned; port 0 may be 1 to 8 bits
    if (P0_W < 1 || P0_W > 8 || P1_W != `GPZ_P1_WIDTH || P2_W != `GPZ_P2_WIDTH) begin : g_chk
        $error("gpz_top: unsupported port width");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte write replaces all bits; bit write touches only the chosen bit
    function automatic gpz_pkg::gpz_byte_t wr_merge(input gpz_pkg::gpz_byte_t old_v,
                                                    input gpz_pkg::gpz_byte_t new_v,
                                                    input logic bit_op,
                                                    input logic [2:0] bit_n);
        gpz_pkg::gpz_byte_t m;
        m = bit_op ? (8'h01 << bit_n) : 8'hff;
        return (old_v & ~m) | (new_v & m);
    endfunction

    // bit read keeps only the chosen bit in place
    function automatic gpz_pkg::gpz_byte_t rd_shape(input gpz_pkg::gpz_byte_t v,
                                                    input logic bit_op,
                                                    input logic [2:0] bit_n);
        return bit_op ? (v & (8'h01 << bit_n)) : v;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    gpz_pkg::gpz_sel_t sel;
    logic [P0_W-1:0]   p0_data_q;
    logic [P1_W-1:0]   p1_data_q;
    logic [P2_W-1:0]   p2_data_q;
    logic [P0_W-1:0]   p0_dir_q;
    logic [P1_W-1:0]   p1_dir_q;
    logic [P2_W-1:0]   p2_dir_q;
    logic [P1_W-1:0]   p1_func_q;
    logic [P2_W-1:0]   p2_func_q;
    logic [P0_W-1:0]   p0_pu_q;
    logic [P1_W-1:0]   p1_pu_q;
    logic [7:0]        rdata_q;
    logic [7:0]        rd_byte;
    logic [P1_W-1:0]   p1_alt_out;
    logic [P1_W-1:0]   p1_alt_oe;

    // address decode; anything else selects nothing
    always_comb begin
        if (ADDR_I == `GPZ_ADDR_P0_DATA) begin
            sel = gpz_pkg::SEL_P0_DATA;
        end else if (ADDR_I == `GPZ_ADDR_P1_DATA) begin
            sel = gpz_pkg::SEL_P1_DATA;
        end else if (ADDR_I == `GPZ_ADDR_P2_DATA) begin
            sel = gpz_pkg::SEL_P2_DATA;
        end else if (ADDR_I == `GPZ_ADDR_P0_DIR) begin
            sel = gpz_pkg::SEL_P0_DIR;
        end else if (ADDR_I == `GPZ_ADDR_P1_DIR) begin
            sel = gpz_pkg::SEL_P1_DIR;
        end else if (ADDR_I == `GPZ_ADDR_P2_DIR) begin
            sel = gpz_pkg::SEL_P2_DIR;
        end else if (ADDR_I == `GPZ_ADDR_P1_FUNC) begin
            sel = gpz_pkg::SEL_P1_FUNC;
        end else if (ADDR_I == `GPZ_ADDR_P2_FUNC) begin
            sel = gpz_pkg::SEL_P2_FUNC;
        end else if (ADDR_I == `GPZ_ADDR_P0_PU) begin
            sel = gpz_pkg::SEL_P0_PU;
        end else if (ADDR_I == `GPZ_ADDR_P1_PU) begin
            sel = gpz_pkg::SEL_P1_PU;
        end else begin
            sel = gpz_pkg::SEL_NONE;
        end
    end

    // data latches; they hold even while a pin is an input
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            p0_data_q <= P0_W'(`GPZ_RST_DATA);
            p1_data_q <= P1_W'(`GPZ_RST_DATA);
            p2_data_q <= P2_W'(`GPZ_RST_DATA);
        end else if (WR_I) begin
            if (sel == gpz_pkg::SEL_P0_DATA) begin
                p0_data_q <= P0_W'(wr_merge(8'(p0_data_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P1_DATA) begin
                p1_data_q <= P1_W'(wr_merge(8'(p1_data_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P2_DATA) begin
                p2_data_q <= P2_W'(wr_merge(8'(p2_data_q), WDATA_I, BITOP_I, BITSEL_I));
            end
        end
    end

    // direction registers; truncation drops writes to missing bits
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            p0_dir_q <= P0_W'(`GPZ_RST_P0_DIR);
            p1_dir_q <= P1_W'(`GPZ_RST_P1_DIR);
            p2_dir_q <= P2_W'(`GPZ_RST_P2_DIR);
        end else if (WR_I) begin
            if (sel == gpz_pkg::SEL_P0_DIR) begin
                p0_dir_q <= P0_W'(wr_merge(8'(p0_dir_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P1_DIR) begin
                p1_dir_q <= P1_W'(wr_merge(8'(p1_dir_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P2_DIR) begin
                p2_dir_q <= P2_W'(wr_merge(8'(p2_dir_q), WDATA_I, BITOP_I, BITSEL_I));
            end
        end
    end

    // function select: a set bit hands the pin to its peripheral
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            p1_func_q <= P1_W'(`GPZ_RST_FUNC);
            p2_func_q <= P2_W'(`GPZ_RST_FUNC);
        end else if (WR_I) begin
            if (sel == gpz_pkg::SEL_P1_FUNC) begin
                p1_func_q <= P1_W'(wr_merge(8'(p1_func_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P2_FUNC) begin
                p2_func_q <= P2_W'(wr_merge(8'(p2_func_q), WDATA_I, BITOP_I, BITSEL_I));
            end
        end
    end

    // pull-up enables
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            p0_pu_q <= P0_W'(`GPZ_RST_PU);
            p1_pu_q <= P1_W'(`GPZ_RST_PU);
        end else if (WR_I) begin
            if (sel == gpz_pkg::SEL_P0_PU) begin
                p0_pu_q <= P0_W'(wr_merge(8'(p0_pu_q), WDATA_I, BITOP_I, BITSEL_I));
            end
            if (sel == gpz_pkg::SEL_P1_PU) begin
                p1_pu_q <= P1_W'(wr_merge(8'(p1_pu_q), WDATA_I, BITOP_I, BITSEL_I));
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // data reads mix pin level (input pins) and latch (output pins)
    always_comb begin
        rd_byte = 8'h00;
        case (sel)
            gpz_pkg::SEL_P0_DATA: rd_byte = 8'((p0_dir_q & P0_IN_I) | (~p0_dir_q & p0_data_q));
            gpz_pkg::SEL_P1_DATA: rd_byte = 8'((p1_dir_q & P1_IN_I) | (~p1_dir_q & p1_data_q));
            gpz_pkg::SEL_P2_DATA: rd_byte = 8'((p2_dir_q & P2_IN_I) | (~p2_dir_q & p2_data_q));
            gpz_pkg::SEL_P0_DIR:  rd_byte = 8'(p0_dir_q);
            gpz_pkg::SEL_P1_DIR:  rd_byte = 8'(p1_dir_q);
            gpz_pkg::SEL_P2_DIR:  rd_byte = 8'(p2_dir_q);
            gpz_pkg::SEL_P1_FUNC: rd_byte = 8'(p1_func_q);
            gpz_pkg::SEL_P2_FUNC: rd_byte = 8'(p2_func_q);
            gpz_pkg::SEL_P0_PU:   rd_byte = 8'(p0_pu_q);
            gpz_pkg::SEL_P1_PU:   rd_byte = 8'(p1_pu_q);
            default:              rd_byte = 8'h00;
        endcase
    end

    // read data stands for exactly one cycle after the strobe
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_q <= 8'h00;
        end else if (RD_I) begin
            rdata_q <= rd_shape(rd_byte, BITOP_I, BITSEL_I);
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign RDATA_O = rdata_q;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // port 0 alternates are inputs only, so the pin stays a plain port
    assign P0_OUT_O    = p0_data_q;
    assign P0_OE_O     = ~p0_dir_q;
    assign P0_PULLUP_O = p0_pu_q;
    assign P0_IRQ_IN_O = P0_IN_I;

    // port 1 peripheral outputs; input-only functions never drive
    always_comb begin
        p1_alt_out = '0;
        p1_alt_oe  = '0;
        p1_alt_out[`GPZ_B_SER_OUT] = SYNC_SERIAL_OUT_I;
        p1_alt_oe[`GPZ_B_SER_OUT]  = 1'b1;
        p1_alt_out[`GPZ_B_SER_CLK] = SYNC_SERIAL_CLOCK_I;
        p1_alt_oe[`GPZ_B_SER_CLK]  = SYNC_SERIAL_CLOCK_OE_I;
        p1_alt_out[`GPZ_B_U1_TX]   = FIRST_UART_TRANSMIT_I;
        p1_alt_oe[`GPZ_B_U1_TX]    = 1'b1;
        p1_alt_out[`GPZ_B_U2_TX]   = SECOND_UART_TRANSMIT_I;
        p1_alt_oe[`GPZ_B_U2_TX]    = 1'b1;
    end

    // control mode swaps the port latch and direction for the peripheral
    assign P1_OUT_O    = (p1_func_q & p1_alt_out) | (~p1_func_q & p1_data_q);
    assign P1_OE_O     = (p1_func_q & p1_alt_oe) | (~p1_func_q & ~p1_dir_q);
    assign P1_PULLUP_O = p1_pu_q;

    // receivers see the pin in either mode; gating is the peripheral's job
    assign SYNC_SERIAL_IN_O      = P1_IN_I[`GPZ_B_SER_IN];
    assign SYNC_SERIAL_CLOCK_O   = P1_IN_I[`GPZ_B_SER_CLK];
    assign FIRST_UART_RECEIVE_O  = P1_IN_I[`GPZ_B_U1_RX];
    assign EXT_INTERRUPT_FOUR_O  = P1_IN_I[`GPZ_B_U1_RX];
    assign SECOND_UART_RECEIVE_O = P1_IN_I[`GPZ_B_U2_RX];
    assign EXT_INTERRUPT_FIVE_O  = P1_IN_I[`GPZ_B_U2_RX];

    // port 2 timer pins
    assign P2_OUT_O   = (p2_func_q & TIMER_OUT_I) | (~p2_func_q & p2_data_q);
    assign P2_OE_O    = (p2_func_q & TIMER_OE_I) | (~p2_func_q & ~p2_dir_q);
    assign TIMER_IN_O = P2_IN_I;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_p0dir_reset: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        $rose(RESETN_I) |-> (8'(p0_dir_q) == `GPZ_RST_P0_DIR))
        else $error("port 0 direction not at reset value");

    a_p1dir_reset: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        $rose(RESETN_I) |-> (8'(p1_dir_q) == `GPZ_RST_P1_DIR) && (p1_data_q == '0))
        else $error("port 1 direction or data not at reset value");

    a_pullup_reset: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        $rose(RESETN_I) |-> (p0_pu_q == '0) && (p1_pu_q == '0) && (P1_PULLUP_O == '0))
        else $error("pull-up enables not cleared by reset");

    a_byte_write: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && !BITOP_I && sel == gpz_pkg::SEL_P1_DATA)
        |=> (p1_data_q == P1_W'($past(WDATA_I))))
        else $error("port 1 byte write not stored");

    a_bit_write: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && BITOP_I && sel == gpz_pkg::SEL_P2_DATA)
        |=> (((p2_data_q ^ $past(p2_data_q)) & ~(8'h01 << $past(BITSEL_I))) == 8'h00)
            && (((p2_data_q ^ $past(WDATA_I)) & (8'h01 << $past(BITSEL_I))) == 8'h00))
        else $error("port 2 bit write disturbed other bits");

    a_dir_to_oe: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && !BITOP_I && sel == gpz_pkg::SEL_P0_DIR)
        |=> (P0_OE_O == ~P0_W'($past(WDATA_I))))
        else $error("port 0 output enable does not follow direction");

    a_pin_readback: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && !BITOP_I && sel == gpz_pkg::SEL_P1_DATA)
        |=> (RDATA_O == {1'b0, ($past(p1_dir_q) & $past(P1_IN_I))
                              | (~$past(p1_dir_q) & $past(p1_data_q))}))
        else $error("port 1 data read wrong");

    a_reserved_zero: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && sel == gpz_pkg::SEL_P0_DIR) ##1 (RD_I && sel == gpz_pkg::SEL_P1_PU)
        |-> (RDATA_O[7:5] == 3'h0) ##1 (RDATA_O[7] == 1'b0))
        else $error("unimplemented bits read nonzero");

    a_read_once: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !RD_I |=> (RDATA_O == 8'h00))
        else $error("read data held past its cycle");

    a_uart_map: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        p1_func_q[`GPZ_B_U1_TX] |-> P1_OE_O[`GPZ_B_U1_TX]
            && (P1_OUT_O[`GPZ_B_U1_TX] == FIRST_UART_TRANSMIT_I)
            && (EXT_INTERRUPT_FOUR_O == P1_IN_I[`GPZ_B_U1_RX]))
        else $error("first uart pin mapping broken");

    a_timer_sel: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && !BITOP_I && sel == gpz_pkg::SEL_P2_FUNC && WDATA_I == 8'hff)
        |=> (P2_OE_O == TIMER_OE_I) && (P2_OUT_O == TIMER_OUT_I))
        else $error("port 2 not handed to timers");

    // bit read zeroes other bits
    a_bit_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && BITOP_I) |=> ((RDATA_O & ~(8'h01 << $past(BITSEL_I))) == 8'h00))
        else $error("bit read leaked other bits");

    // unmapped reads give zero
    a_unmapped_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && sel == gpz_pkg::SEL_NONE) |=> (RDATA_O == 8'h00))
        else $error("unmapped read nonzero");

    // pull-up pins follow a byte write
    a_pullup_write: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && !BITOP_I && sel == gpz_pkg::SEL_P0_PU)
        |=> (P0_PULLUP_O == P0_W'($past(WDATA_I))))
        else $error("port 0 pull-up wrong");

    // bit write sets the chosen enable to the inverted data bit
    a_p2_bit_oe: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && BITOP_I && sel == gpz_pkg::SEL_P2_DIR && p2_func_q == '0)
        |=> (((P2_OE_O ^ ~$past(WDATA_I)) & (8'h01 << $past(BITSEL_I))) == 8'h00))
        else $error("port 2 bit enable wrong");

    // port mode again after control mode
    a_p1_port_mode: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && !BITOP_I && sel == gpz_pkg::SEL_P1_FUNC && WDATA_I == 8'h00)
        |=> (P1_OE_O == ~p1_dir_q))
        else $error("port 1 not in port mode");

    // main scenarios
    c_bit_write: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        WR_I && BITOP_I && sel == gpz_pkg::SEL_P1_DIR);
    c_input_read: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        RD_I && sel == gpz_pkg::SEL_P2_DATA && p2_dir_q != '0);
    c_uart_mode: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        p1_func_q[`GPZ_B_U2_TX] && P1_OE_O[`GPZ_B_U2_TX]);
    c_back_to_back: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        WR_I ##1 RD_I);
    c_timer_mode: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        p2_func_q != '0 && TIMER_OE_I != '0);

endmodule
`default_nettype wire

// ===== verif/gpz_board.sv
/*
 * Board-side model of one GPIO port: resolves each pin from the
 * device drive, its pull-up and a weak outside level.
 * Assumes out, oe and pull-up come straight from the device.
 */
`timescale 1ns/10ps
`default_nettype none
module gpz_board #(
    parameter int W = 8
) (
    // device side
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    // outside level and resolved pin
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pin_o
);
    // driven pins win; an undriven pin with pull-up reads high
    assign pin_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
endmodule
`default_nettype wire

// ===== verif/gpio_ports_zero_to_two_bench.sv
/*
 * Self-checking bench for the port 0..2 GPIO block.
 * Assumes the register port answers reads one cycle after the strobe.
 */
`timescale 1ns/10ps
`include "gpz_params.svh"
`default_nettype none
module gpio_ports_zero_to_two_bench;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic mclk, resetn, wr, rd, bitop, s_out, s_clk, s_clk_oe, u1_tx, u2_tx;
    logic [31:0] addr;
    logic [7:0]  wdata, p2_ext, t_out, t_oe;
    logic [2:0]  bitsel;
    logic [4:0]  p0_ext;
    logic [6:0]  p1_ext;
    wire logic [7:0] rdata, p2_out, p2_oe, p2_pin, t_in;
    wire logic [4:0] p0_out, p0_oe, p0_pu, p0_irq, p0_pin;
    wire logic [6:0] p1_out, p1_oe, p1_pu, p1_pin;
    wire logic s_in, s_clk_o, u1_rx, irq4, u2_rx, irq5;
    int bad_count = 0;
    int tests_run = 0;

    gpz_top uut (.MCLK_I(mclk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .BITOP_I(bitop), .BITSEL_I(bitsel), .RDATA_O(rdata),
        .P0_IN_I(p0_pin), .P0_OUT_O(p0_out), .P0_OE_O(p0_oe), .P0_PULLUP_O(p0_pu),
        .P0_IRQ_IN_O(p0_irq), .P1_IN_I(p1_pin), .P1_OUT_O(p1_out), .P1_OE_O(p1_oe),
        .P1_PULLUP_O(p1_pu), .SYNC_SERIAL_IN_O(s_in), .SYNC_SERIAL_OUT_I(s_out),
        .SYNC_SERIAL_CLOCK_I(s_clk), .SYNC_SERIAL_CLOCK_OE_I(s_clk_oe),
        .SYNC_SERIAL_CLOCK_O(s_clk_o), .FIRST_UART_RECEIVE_O(u1_rx),
        .EXT_INTERRUPT_FOUR_O(irq4), .FIRST_UART_TRANSMIT_I(u1_tx),
        .SECOND_UART_RECEIVE_O(u2_rx), .EXT_INTERRUPT_FIVE_O(irq5),
        .SECOND_UART_TRANSMIT_I(u2_tx), .P2_IN_I(p2_pin), .P2_OUT_O(p2_out),
        .P2_OE_O(p2_oe), .TIMER_IN_O(t_in), .TIMER_OUT_I(t_out), .TIMER_OE_I(t_oe));
    gpz_board #(.W(5)) board0 (.out_i(p0_out), .oe_i(p0_oe), .pu_i(p0_pu),
        .ext_i(p0_ext), .pin_o(p0_pin));
    gpz_board #(.W(7)) board1 (.out_i(p1_out), .oe_i(p1_oe), .pu_i(p1_pu),
        .ext_i(p1_ext), .pin_o(p1_pin));
    // port 2 has no pull-up output, so the outside level alone holds a free pin
    gpz_board #(.W(8)) board2 (.out_i(p2_out), .oe_i(p2_oe), .pu_i(8'h00),
        .ext_i(p2_ext), .pin_o(p2_pin));

    // ----------------------------------------------------------
    // bus cycles and comparison
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // strobe drops at the taking edge; the negedge wait keeps calls apart
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d, input logic b,
                          input logic [2:0] n);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        bitop <= b;
        bitsel <= n;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic b,
                          input logic [2:0] n, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        bitop <= b;
        bitsel <= n;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(what, e, rdata);
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        rd_chk("p1 data", `GPZ_ADDR_P1_DATA, 1'b0, 3'h0, 8'h00);
        rd_chk("p2 data", `GPZ_ADDR_P2_DATA, 1'b0, 3'h0, 8'h00);
        rd_chk("p0 dir", `GPZ_ADDR_P0_DIR, 1'b0, 3'h0, 8'h1f);
        rd_chk("p1 dir", `GPZ_ADDR_P1_DIR, 1'b0, 3'h0, 8'h7f);
        rd_chk("p0 pu", `GPZ_ADDR_P0_PU, 1'b0, 3'h0, 8'h00);
        rd_chk("p1 pu", `GPZ_ADDR_P1_PU, 1'b0, 3'h0, 8'h00);
        rd_chk("unmapped", 32'hfffff0f0, 1'b0, 3'h0, 8'h00);
        chk("oe at reset", 8'h00, 8'(p0_oe | p1_oe));
    endtask
    task automatic t_dir_out;
        p1_ext = 7'h2a;
        wr_reg(`GPZ_ADDR_P1_DATA, 8'hd5, 1'b0, 3'h0);
        wr_reg(`GPZ_ADDR_P1_DIR, 8'h00, 1'b0, 3'h0);
        chk("p1 oe", 8'h7f, 8'(p1_oe));
        chk("p1 out", 8'h55, 8'(p1_out));
        rd_chk("p1 data out", `GPZ_ADDR_P1_DATA, 1'b0, 3'h0, 8'h55);
        wr_reg(`GPZ_ADDR_P1_DIR, 8'hff, 1'b0, 3'h0);
        rd_chk("p1 data in", `GPZ_ADDR_P1_DATA, 1'b0, 3'h0, 8'h2a);
        wr_reg(`GPZ_ADDR_P0_DIR, 8'hf5, 1'b0, 3'h0);
        chk("p0 oe", 8'h0a, 8'(p0_oe));
        wr_reg(`GPZ_ADDR_P0_DIR, 8'hff, 1'b0, 3'h0);
        rd_chk("p0 dir top", `GPZ_ADDR_P0_DIR, 1'b0, 3'h0, 8'h1f);
        p1_ext = 7'h00;
    endtask
    task automatic t_bits;
        wr_reg(`GPZ_ADDR_P2_DATA, 8'h80, 1'b1, 3'h7);
        wr_reg(`GPZ_ADDR_P2_DIR, 8'h00, 1'b1, 3'h7);
        chk("p2 out", 8'h80, p2_out);
        chk("p2 oe", 8'h80, p2_oe);
        rd_chk("p2 bit", `GPZ_ADDR_P2_DATA, 1'b1, 3'h7, 8'h80);
        rd_chk("p1 dir b7", `GPZ_ADDR_P1_DIR, 1'b1, 3'h7, 8'h00);
        wr_reg(`GPZ_ADDR_P1_PU, 8'h40, 1'b1, 3'h6);
        chk("p1 pu bit", 8'h40, 8'(p1_pu));
    endtask
    task automatic t_pullup;
        wr_reg(`GPZ_ADDR_P0_PU, 8'hff, 1'b0, 3'h0);
        chk("p0 pu", 8'h1f, 8'(p0_pu));
        rd_chk("p0 pu rd", `GPZ_ADDR_P0_PU, 1'b0, 3'h0, 8'h1f);
        chk("p0 irq hi", 8'h1f, 8'(p0_irq));
        wr_reg(`GPZ_ADDR_P0_PU, 8'h00, 1'b0, 3'h0);
        p0_ext = 5'h05;
        #1 chk("p0 irq", 8'h05, 8'(p0_irq));
    endtask
    task automatic t_ctrl;
        s_out = 1'b1;
        s_clk = 1'b1;
        s_clk_oe = 1'b1;
        u1_tx = 1'b1;
        p1_ext = 7'h28;
        wr_reg(`GPZ_ADDR_P1_FUNC, 8'h7f, 1'b0, 3'h0);
        chk("p1 ctl oe", 8'h56, 8'(p1_oe));
        chk("p1 ctl out", 8'h16, 8'(p1_out) & 8'h56);
        chk("p1 rx", 8'h0f, {4'h0, u1_rx, irq4, u2_rx, irq5});
        p1_ext = 7'h01;
        #1 chk("p1 sin", 8'h03, {6'h0, s_clk_o, s_in});
        wr_reg(`GPZ_ADDR_P1_FUNC, 8'h00, 1'b0, 3'h0);
        chk("p1 port oe", 8'h00, 8'(p1_oe));
        t_oe = 8'h0f;
        t_out = 8'h05;
        p2_ext = 8'ha0;
        wr_reg(`GPZ_ADDR_P2_FUNC, 8'hff, 1'b0, 3'h0);
        chk("p2 tmr oe", 8'h0f, p2_oe);
        chk("p2 tmr in", 8'ha5, t_in);
    endtask
    // write then reads, no idle gap
    task automatic t_b2b;
        @(posedge mclk);
        addr <= `GPZ_ADDR_P1_PU;
        wdata <= 8'hff;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= `GPZ_ADDR_P0_DIR;
        @(posedge mclk);
        addr <= `GPZ_ADDR_P1_PU;
        @(negedge mclk);
        chk("b2b p0 dir", 8'h1f, rdata);
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk("b2b p1 pu", 8'h7f, rdata);
    endtask

    // ----------------------------------------------------------
    // clock, verdict, watchdog, main sequence
    // ----------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic final_report;
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        final_report();
    end
    initial begin
        {resetn, wr, rd, bitop, s_out, s_clk, s_clk_oe, u1_tx, u2_tx} = '0;
        {addr, wdata, bitsel, p0_ext, p1_ext, p2_ext, t_out, t_oe} = '0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_dir_out();
        t_bits();
        t_pullup();
        t_ctrl();
        t_b2b();
        final_report();
    end
endmodule
`default_nettype wire
